// ### verilog/sfe_pkg.sv
package sfe_pkg;
    // ----------------------------------------
    // Opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_BE4K   = 8'h20;
    localparam logic [7:0] OP_BE32K  = 8'h52;
    localparam logic [7:0] OP_BE64K  = 8'hD8;
    localparam logic [7:0] OP_CE_A   = 8'h60;
    localparam logic [7:0] OP_CE_B   = 8'hC7;
    localparam logic [7:0] OP_STATUS = 8'h25;
    localparam logic [7:0] OP_SUSP   = 8'h75;
    // ----------------------------------------
    // Frame layout and field positions
    // ----------------------------------------
    localparam int         OPC_BITS  = 8;
    localparam logic [5:0] ADDR_LAST = 6'h1F;
    localparam int         SR1_BUSY  = 0;
    localparam int         SR1_WEL   = 1;
    localparam int         SR1_BP_LO = 2;
    localparam logic [23:0] MASK_4K  = 24'h000FFF;
    localparam logic [23:0] MASK_32K = 24'h007FFF;
    localparam logic [23:0] MASK_64K = 24'h00FFFF;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int MCLK_MHZ      = 10;
    localparam int BLK_ERASE_US  = 1000;
    localparam int CHIP_ERASE_US = 20000;
    localparam int CNT_W         = 18;
    localparam logic [CNT_W-1:0] BLK_ERASE_CYC  = CNT_W'(BLK_ERASE_US * MCLK_MHZ);
    localparam logic [CNT_W-1:0] CHIP_ERASE_CYC = CNT_W'(CHIP_ERASE_US * MCLK_MHZ);
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        SFE_SZ_4K   = 2'b00,
        SFE_SZ_32K  = 2'b01,
        SFE_SZ_64K  = 2'b10,
        SFE_SZ_CHIP = 2'b11
    } sfe_size_e;
    typedef enum logic [1:0] {
        SFE_IDLE  = 2'b00,
        SFE_CHECK = 2'b01,
        SFE_ERASE = 2'b10
    } sfe_state_e;
    // Any erase opcode
    function automatic logic sfe_is_erase(input logic [7:0] op);
        return op == OP_BE4K || op == OP_BE32K || op == OP_BE64K ||
               op == OP_CE_A || op == OP_CE_B;
    endfunction : sfe_is_erase
    // Erase size of an erase opcode
    function automatic sfe_size_e sfe_size_of(input logic [7:0] op);
        case (op)
            OP_BE4K:  return SFE_SZ_4K;
            OP_BE32K: return SFE_SZ_32K;
            OP_BE64K: return SFE_SZ_64K;
            default:  return SFE_SZ_CHIP;
        endcase
    endfunction : sfe_size_of
endpackage : sfe_pkg

// ### verilog/sfe_link_rx.sv
`timescale 1ns/1ns
module sfe_link_rx
    import sfe_pkg::*;
(
    // Link side
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe,
    // Core side
    input  wire logic        link_rst,
    input  wire logic        busy_in,
    output logic [5:0]       bit_cnt,
    output logic [7:0]       opcode,
    output logic [23:0]      addr,
    output logic             addr_done,
    output logic             frame_tog
);
    typedef struct packed {
        logic [5:0]  cnt;      // Bits seen this frame
        logic [7:0]  opc;      // Opcode shift register
        logic [23:0] adr;      // Address shift register
        logic        adone;    // All 24 address bits in
        logic        stat;     // Busy-on-output mode
        logic        tog;      // Flips on the first clock of a frame
        logic        bsy1;     // Busy sync, first stage
        logic        bsy2;     // Busy sync, second stage
    } sfe_link_s;
    sfe_link_s r_reg, r_next;
    logic      fresh;          // Next edge is first of a frame
    logic [5:0] idx;
    logic       past;

    // ----------------------------------------
    // Frame start marker
    // ----------------------------------------
    // Set while chip select is high; no edge exists to clear it then
    always_ff @(posedge sck or posedge cs_n or posedge link_rst) begin
        if (cs_n || link_rst) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Shift in on rising edges, MSB first
    always_comb begin
        r_next      = r_reg;
        r_next.bsy1 = busy_in;
        r_next.bsy2 = r_reg.bsy1;
        idx         = fresh ? 6'h00 : r_reg.cnt;
        past        = fresh ? 1'b0 : r_reg.adone;
        if (fresh) begin
            r_next.tog  = ~r_reg.tog;
            r_next.stat = 1'b0;
            r_next.adone = 1'b0;
        end
        if (!past && idx < 6'(OPC_BITS)) begin
            r_next.opc = {r_reg.opc[6:0], si};
        end else if (!past) begin
            r_next.adr = {r_reg.adr[22:0], si};
        end
        if (!past && idx == ADDR_LAST) begin
            r_next.adone = 1'b1;
        end
        if (idx == 6'(OPC_BITS - 1) && {r_reg.opc[6:0], si} == OP_STATUS) begin
            r_next.stat = 1'b1;
        end
        r_next.cnt = idx + 6'h01;
    end

    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Busy driven out on falling edges, released as the frame ends;
    // core reset clears it too, since chip select may never rise
    always_ff @(negedge sck or posedge cs_n or posedge link_rst) begin
        if (cs_n || link_rst) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so    <= r_reg.bsy2;
            so_oe <= r_reg.stat;
        end
    end

    assign bit_cnt   = r_reg.cnt;
    assign opcode    = r_reg.opc;
    assign addr      = r_reg.adr;
    assign addr_done = r_reg.adone;
    assign frame_tog = r_reg.tog;
endmodule : sfe_link_rx

// ### verilog/sfe_erase_timer.sv
`timescale 1ns/1ns
module sfe_erase_timer
    import sfe_pkg::*;
#(
    parameter logic [CNT_W-1:0] BLK_CYC  = BLK_ERASE_CYC,
    parameter logic [CNT_W-1:0] CHIP_CYC = CHIP_ERASE_CYC
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic chip,
    input  wire logic fail_in,
    output logic      active,
    output logic      done,
    output logic      failed
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;  // Elapsed erase cycles
        logic             act;  // Erase running
        logic             chp;  // Running a full-array erase
        logic             dn;   // One-cycle completion
        logic             fl;   // Failure of last erase
        logic             seen; // Failure seen during this erase
        logic             f1;   // Verify sync, first stage
        logic             f2;   // Verify sync, second stage
    } sfe_tmr_s;
    sfe_tmr_s r_reg, r_next;
    logic [CNT_W-1:0] limit;

    // Self-timed erase; the array verify line is asynchronous
    always_comb begin
        r_next    = r_reg;
        r_next.f1 = fail_in;
        r_next.f2 = r_reg.f1;
        r_next.dn = 1'b0;
        limit     = r_reg.chp ? CHIP_CYC : BLK_CYC;
        if (start) begin
            r_next.act  = 1'b1;
            r_next.chp  = chip;
            r_next.cnt  = '0;
            r_next.seen = 1'b0;
        end else if (r_reg.act) begin
            if (r_reg.f2) begin
                r_next.seen = 1'b1;
            end
            if (r_reg.cnt == limit - CNT_W'(1)) begin
                r_next.act = 1'b0;
                r_next.dn  = 1'b1;
                r_next.fl  = r_reg.seen | r_reg.f2;
            end else begin
                r_next.cnt = r_reg.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign active = r_reg.act;
    assign done   = r_reg.dn;
    assign failed = r_reg.fl;
endmodule : sfe_erase_timer

// ### verilog/sfe_erase_ctrl.sv
`timescale 1ns/1ns
module sfe_erase_ctrl
    import sfe_pkg::*;
#(
    parameter logic [CNT_W-1:0] BLK_CYC  = BLK_ERASE_CYC,
    parameter logic [CNT_W-1:0] CHIP_CYC = CHIP_ERASE_CYC
)(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Serial link
    input  wire logic        SCK,
    input  wire logic        CS_N,
    input  wire logic        SI,
    output logic             SO,
    output logic             SO_OE,
    // Protection state
    input  wire logic [2:0]  BLOCK_PROTECT_FIELD,
    input  wire logic        LOCK_SELECT_BIT,
    input  wire logic        BLOCK_LOCKED,
    input  wire logic        ANY_BLOCK_LOCKED,
    // Array side
    input  wire logic        ERASE_FAIL,
    output logic             ERASE_ACTIVE,
    output logic [23:0]      ERASE_ADDR,
    output logic [1:0]       ERASE_SIZE,
    output logic             SUSPEND_REQ,
    // Status
    output logic             BUSY_FLAG,
    output logic             WRITE_ENABLE_LATCH,
    output logic             ERASE_ERROR_FLAG,
    output logic             PROGRAM_ERROR_FLAG,
    output logic [7:0]       STATUS_REG_ONE
);
    // ----------------------------------------
    // Core state
    // ----------------------------------------
    typedef struct packed {
        sfe_state_e  st;     // Sequencer state
        logic        cs1;    // Chip select sync, first stage
        logic        cs2;    // Chip select sync, second stage
        logic        cs3;    // Edge history of cs2
        logic        tg1;    // Frame toggle sync, first stage
        logic        tg2;    // Frame toggle sync, second stage
        logic        tgs;    // Last frame toggle consumed
        logic        lrst;   // Reset for the link logic
        logic        write_enable_latch;    // Write-enable latch
        logic        bsy;    // Busy flag
        logic        ee;     // Erase error flag
        logic        pe;     // Program error flag
        logic [23:0] adr;    // Erase address, low bits cleared
        sfe_size_e   sz;     // Erase size
        logic        go;     // Start pulse to the timer
        logic        sus;    // Suspend pulse to the array
        logic [7:0]  sr1;    // First status register image
    } sfe_core_s;
    sfe_core_s r_reg, r_next;

    // Link outputs; quasi-static once chip select is high
    logic [5:0]  lk_cnt;       // Bits in the frame, wraps at 64
    logic [7:0]  lk_op;        // Captured opcode
    logic [23:0] lk_adr;       // Captured address
    logic        lk_adone;     // Full address seen
    logic        lk_tog;       // Frame toggle
    // Timer
    logic        tm_act;       // Erase running
    logic        tm_done;      // Erase finished this cycle
    logic        tm_fail;      // Last erase failed
    // Decodes
    logic        frame_end;    // Chip select rose, synced
    logic        frame_new;    // ...and the frame held bits
    logic        aligned;      // Frame ended on a byte
    logic        is_chip;      // Pending erase is full-array
    logic        prot;         // Pending erase hits protection
    logic        bp_hit;       // Block protect covers block

    // ----------------------------------------
    // Link receiver, runs on the serial clock
    // ----------------------------------------
    sfe_link_rx u_link (
        .sck       (SCK),
        .cs_n      (CS_N),
        .si        (SI),
        .so        (SO),
        .so_oe     (SO_OE),
        .link_rst  (r_reg.lrst),
        .busy_in   (r_reg.bsy),
        .bit_cnt   (lk_cnt),
        .opcode    (lk_op),
        .addr      (lk_adr),
        .addr_done (lk_adone),
        .frame_tog (lk_tog)
    );

    // ----------------------------------------
    // Self-timed erase
    // ----------------------------------------
    sfe_erase_timer #(
        .BLK_CYC  (BLK_CYC),
        .CHIP_CYC (CHIP_CYC)
    ) u_timer (
        .clk     (MCLK),
        .rst     (RST),
        .start   (r_reg.go),
        .chip    (r_reg.sz == SFE_SZ_CHIP),
        .fail_in (ERASE_FAIL),
        .active  (tm_act),
        .done    (tm_done),
        .failed  (tm_fail)
    );

    // Top protected 64K blocks grow by powers of two; 7 covers all
    function automatic logic sfe_bp_covers(input logic [2:0] bp,
                                           input logic [4:0] blk);
        logic [5:0] span;
        span = 6'h01 << (bp - 3'h1);
        if (bp == 3'h0) begin
            return 1'b0;
        end else if (bp == 3'h7) begin
            return 1'b1;
        end
        return {1'b0, blk} >= (6'h20 - span);
    endfunction : sfe_bp_covers

    // Clear the bits that the erase size makes meaningless
    function automatic logic [23:0] sfe_mask(input logic [23:0] a,
                                             input sfe_size_e sz);
        case (sz)
            SFE_SZ_4K:  return a & ~MASK_4K;
            SFE_SZ_32K: return a & ~MASK_32K;
            SFE_SZ_64K: return a & ~MASK_64K;
            default:    return 24'h000000;
        endcase
    endfunction : sfe_mask

    // ----------------------------------------
    // Frame decode
    // ----------------------------------------
    // A frame with no clocks leaves the toggle alone and is dropped,
    // so a bare chip select pulse cannot replay the previous command
    always_comb begin
        frame_end = r_reg.cs2 & ~r_reg.cs3;
        frame_new = frame_end & (r_reg.tg2 != r_reg.tgs);
        aligned   = lk_cnt[2:0] == 3'h0;
        is_chip   = r_reg.sz == SFE_SZ_CHIP;
        bp_hit    = sfe_bp_covers(BLOCK_PROTECT_FIELD, r_reg.adr[20:16]);
        if (is_chip) begin
            prot = (BLOCK_PROTECT_FIELD != 3'h0) ||
                   (LOCK_SELECT_BIT && ANY_BLOCK_LOCKED);
        end else begin
            prot = bp_hit || (LOCK_SELECT_BIT && BLOCK_LOCKED);
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        r_next      = r_reg;
        r_next.cs1  = CS_N;
        r_next.cs2  = r_reg.cs1;
        r_next.cs3  = r_reg.cs2;
        r_next.tg1  = lk_tog;
        r_next.tg2  = r_reg.tg1;
        r_next.lrst = 1'b0;
        r_next.go   = 1'b0;
        r_next.sus  = 1'b0;
        if (frame_end) begin
            r_next.tgs = r_reg.tg2;
        end
        case (r_reg.st)
            SFE_IDLE: begin
                // Write-enable and erase commands arriving while busy are ignored
                if (frame_new && !r_reg.bsy) begin
                    if (lk_op == OP_WREN && aligned) begin
                        r_next.write_enable_latch = 1'b1;
                    end else if (sfe_is_erase(lk_op)) begin
                        if (!aligned) begin
                            r_next.write_enable_latch = 1'b0;
                        end else if (sfe_size_of(lk_op) != SFE_SZ_CHIP &&
                                     !lk_adone) begin
                            r_next.write_enable_latch = 1'b0;
                        end else if (r_reg.write_enable_latch) begin
                            // Opcode only for full erase, address else
                            r_next.sz  = sfe_size_of(lk_op);
                            r_next.adr = sfe_mask(lk_adr, sfe_size_of(lk_op));
                            r_next.st  = SFE_CHECK;
                        end
                    end
                end
            end
            SFE_CHECK: begin
                // One cycle lets outside lock lookup see ERASE_ADDR
                if (prot) begin
                    r_next.write_enable_latch = 1'b0;
                    r_next.st  = SFE_IDLE;
                end else begin
                    r_next.go  = 1'b1;
                    r_next.write_enable_latch = 1'b0;
                    r_next.bsy = 1'b1;
                    r_next.ee  = 1'b0;
                    r_next.pe  = 1'b0;
                    r_next.st  = SFE_ERASE;
                end
            end
            SFE_ERASE: begin
                // Suspend only forwarded for block erases
                if (frame_new && lk_op == OP_SUSP && aligned && !is_chip) begin
                    r_next.sus = 1'b1;
                end
                if (tm_done) begin
                    r_next.bsy = 1'b0;
                    r_next.ee  = tm_fail;
                    r_next.pe  = tm_fail;
                    r_next.st  = SFE_IDLE;
                end
            end
            default: begin
                r_next.st = SFE_IDLE;
            end
        endcase
        r_next.sr1 = 8'h00;
        r_next.sr1[SR1_BUSY] = r_next.bsy;
        r_next.sr1[SR1_WEL]  = r_next.write_enable_latch;
        r_next.sr1[SR1_BP_LO +: 3] = BLOCK_PROTECT_FIELD;
    end

    // Synchronous reset; link logic held in reset alongside
    always_ff @(posedge MCLK) begin
        if (RST) begin
            r_reg      <= '0;
            r_reg.cs1  <= 1'b1;
            r_reg.cs2  <= 1'b1;
            r_reg.cs3  <= 1'b1;
            r_reg.lrst <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ERASE_ACTIVE       = tm_act;
    assign ERASE_ADDR         = r_reg.adr;
    assign ERASE_SIZE         = r_reg.sz;
    assign SUSPEND_REQ        = r_reg.sus;
    assign BUSY_FLAG          = r_reg.bsy;
    assign WRITE_ENABLE_LATCH = r_reg.write_enable_latch;
    assign ERASE_ERROR_FLAG   = r_reg.ee;
    assign PROGRAM_ERROR_FLAG = r_reg.pe;
    assign STATUS_REG_ONE     = r_reg.sr1;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    sequence s_launch;
        r_reg.st == SFE_CHECK && !prot;
    endsequence
    sequence s_running;
        BUSY_FLAG && !WRITE_ENABLE_LATCH && r_reg.st == SFE_ERASE;
    endsequence
    sequence s_erase_frame;
        frame_new && !r_reg.bsy && sfe_is_erase(lk_op);
    endsequence

    property p_launch;
        s_launch |=> s_running ##1 $rose(ERASE_ACTIVE);
    endproperty
    a_launch: assert property (p_launch) else $error("erase launch wrong");

    property p_busy_cover;
        ERASE_ACTIVE |-> BUSY_FLAG && STATUS_REG_ONE[SR1_BUSY];
    endproperty
    a_busy_cover: assert property (p_busy_cover) else $error("busy low in erase");

    property p_misaligned;
        s_erase_frame ##0 !aligned |=> !WRITE_ENABLE_LATCH ##0 r_reg.st == SFE_IDLE;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned not aborted");

    property p_short_addr;
        s_erase_frame ##0 (aligned && sfe_size_of(lk_op) != SFE_SZ_CHIP && !lk_adone)
            |=> !WRITE_ENABLE_LATCH ##1 !ERASE_ACTIVE;
    endproperty
    a_short_addr: assert property (p_short_addr) else $error("short address ran");

    property p_protected;
        r_reg.st == SFE_CHECK && prot |=> (!WRITE_ENABLE_LATCH && !BUSY_FLAG) [*2];
    endproperty
    a_protected: assert property (p_protected) else $error("protected erase ran");

    property p_error;
        tm_done && tm_fail |=> ERASE_ERROR_FLAG && PROGRAM_ERROR_FLAG && !BUSY_FLAG;
    endproperty
    a_error: assert property (p_error) else $error("error flags missing");

    property p_no_suspend_chip;
        r_reg.st == SFE_ERASE && ERASE_SIZE == SFE_SZ_CHIP |=> !SUSPEND_REQ;
    endproperty
    a_no_suspend_chip: assert property (p_no_suspend_chip) else $error("suspend in chip");

    property p_need_wel;
        s_erase_frame ##0 !WRITE_ENABLE_LATCH |=> r_reg.st == SFE_IDLE ##1 !ERASE_ACTIVE;
    endproperty
    a_need_wel: assert property (p_need_wel) else $error("erase without latch");

    property p_mask;
        r_reg.st == SFE_ERASE |-> (ERASE_SIZE != SFE_SZ_4K || ERASE_ADDR[11:0] == 12'h000)
            && (ERASE_SIZE != SFE_SZ_64K || ERASE_ADDR[15:0] == 16'h0000)
            && (ERASE_SIZE != SFE_SZ_32K || ERASE_ADDR[14:0] == 15'h0000);
    endproperty
    a_mask: assert property (p_mask) else $error("low address bits kept");

    property p_wren;
        frame_new && !r_reg.bsy && lk_op == OP_WREN && aligned
            && r_reg.st == SFE_IDLE |=> WRITE_ENABLE_LATCH;
    endproperty
    a_wren: assert property (p_wren) else $error("latch not set");
endmodule : sfe_erase_ctrl

// ### verification/sfe_spi_host.sv
`timescale 1ns/1ns
module sfe_spi_host (
    // Link pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    logic so_last;  // Serial output seen at the last rising edge
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        so_last = 1'b0;
    end
    // ----------------------------------------
    // One frame, first bit at d[31]
    // ----------------------------------------
    // The link clock only runs inside a frame
    task automatic send(input logic [31:0] d, input int n);
        #27 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = d[31-i];
            #32 sck = 1'b1;
            so_last = so;
            #32 sck = 1'b0;
        end
        #20 cs_n = 1'b1;
        si = ~si;  // Released line must not keep its last value
        #600;  // Gap above the 400 ns minimum
    endtask : send
endmodule : sfe_spi_host

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Signals and case table
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] d;   // Frame bits
        logic [5:0]  nb;  // Bits sent
        logic [2:0]  bp;  // Protect field
        logic        lk;  // Block locks on
        logic        go;  // Erase expected
        logic [25:0] ex;  // Size and erase address
    } sfe_row_s;
    logic mclk, rst, sck, cs_n, si, so, so_oe, fail, lk, act, susp, busy, write_enable_latch, ee, pe;
    logic [2:0]  bp;
    logic [25:0] sa;
    logic [7:0]  sr1;
    int          error_cnt = 0;
    int          checks = 0;
    int          susp_cnt = 0;
    int          oe_cnt = 0;
    sfe_row_s    rows[10] = '{
        '{32'h20123ABC, 6'h20, 3'h0, 1'b0, 1'b1, 26'h0123000},
        '{32'h5212FFFF, 6'h20, 3'h0, 1'b0, 1'b1, 26'h1128000},
        '{32'hD81ABCDE, 6'h20, 3'h0, 1'b0, 1'b1, 26'h21A0000},
        '{32'h60000000, 6'h08, 3'h0, 1'b0, 1'b1, 26'h3000000},
        '{32'hC7000000, 6'h08, 3'h0, 1'b0, 1'b1, 26'h3000000},
        '{32'h20123ABC, 6'h18, 3'h0, 1'b0, 1'b0, 26'h0000000},
        '{32'h20123ABC, 6'h1D, 3'h0, 1'b0, 1'b0, 26'h0000000},
        '{32'h60000000, 6'h08, 3'h1, 1'b0, 1'b0, 26'h0000000},
        '{32'h60000000, 6'h08, 3'h0, 1'b1, 1'b0, 26'h0000000},
        '{32'hD81F0000, 6'h20, 3'h7, 1'b0, 1'b0, 26'h0000000}};
    sfe_spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    sfe_erase_ctrl #(.BLK_CYC(18'h28), .CHIP_CYC(18'h3C)) dut (
        .MCLK(mclk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
        .BLOCK_PROTECT_FIELD(bp), .LOCK_SELECT_BIT(lk), .BLOCK_LOCKED(lk),
        .ANY_BLOCK_LOCKED(lk), .ERASE_FAIL(fail), .ERASE_ACTIVE(act),
        .ERASE_ADDR(sa[23:0]), .ERASE_SIZE(sa[25:24]), .SUSPEND_REQ(susp),
        .BUSY_FLAG(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .ERASE_ERROR_FLAG(ee),
        .PROGRAM_ERROR_FLAG(pe), .STATUS_REG_ONE(sr1));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Suspend pulses are one cycle, so count them as they pass
    always @(posedge mclk) if (susp === 1'b1) susp_cnt++;
    // Serial clocks that saw the output enabled; it only moves on falling edges, as chip select rises or on link reset
    always @(posedge sck) if (so_oe === 1'b1) oe_cnt++;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for the erase to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        if (busy !== 1'b0) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_idle
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {rst, fail, lk, bp} = 6'h20;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            bp <= rows[i].bp;
            lk <= rows[i].lk;
            host.send(32'h06000000, 8);
            chk(write_enable_latch, 1'b1);
            host.send(rows[i].d, int'(rows[i].nb));
            repeat (4) @(posedge mclk);
            chk(busy, rows[i].go);
            chk(sr1[4:0], {rows[i].bp, 1'b0, rows[i].go});
            chk(write_enable_latch, 1'b0);
            if (rows[i].go) begin
                chk(sa, rows[i].ex);
            end
            wait_idle();
            chk(act, 1'b0);
            $display("case %0d done", i);
        end
        bp <= 3'h0;  // Last row left everything protected
        host.send(32'h20000000, 32);
        repeat (4) @(posedge mclk);
        chk(busy, 1'b0);
        host.send(32'h06000000, 8);
        @(posedge mclk);
        fail <= 1'b1;
        host.send(32'h20000000, 32);
        host.send(32'h25000000, 16);
        chk(host.so_last, 1'b1);
        chk(oe_cnt, 8);
        chk(so_oe, 1'b0);
        host.send(32'h75000000, 8);
        wait_idle();
        chk({ee, pe}, 2'h3);
        chk(susp_cnt, 1);
        fail <= 1'b0;
        host.send(32'h06000000, 8);
        host.send(32'hC7000000, 8);
        host.send(32'h75000000, 8);
        chk(busy, 1'b1);
        wait_idle();
        chk(susp_cnt, 1);
        chk({ee, pe}, 2'h0);
        $display("status and suspend done");
        host.send(32'h06000000, 8);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({sr1, write_enable_latch, busy, ee}, 0);
        $display("reset done");
        wrap_up();
    end
endmodule : tb_top
